/* File: flash_host_pkg.sv */
// Purpose: Shared constants and types of the flash unlock-bypass host controller.
// Assumes: 16-bit NOR bank on an asynchronous parallel bus, host clock 20 MHz.
// Notes: Behaviour list below.
//
// Behaviour
// - Bypass entry writes 00aa at base+555, 0055 at base+2aa, 0020 at base+555.
// - Bypass program writes 00a0 anywhere in bank, then data at target address.
// - Bypass exit writes 0090 then 0000 to the bank; bank returns to read mode.
// - Host runs one operation type in bypass and exits before another type.
// - Buffer programs poll only the last loaded word of the page.
// - Bit 7 may turn to data before bits 6..0; confirm on a following read.
// - Toggle advances only between distinct reads; strobes must rise between reads.
// - Host reads status twice and compares toggle; unchanged means done.
// - Toggling with timing-limit high: recheck; still toggling means fail, reset.
package flash_host_pkg;
  localparam int DQ_W = 16;
  localparam int ADDR_W_DEF = 24;
  localparam int REG_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_BASE = 8'h10;
  // Control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_BYPASS = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_RD_LSB = 16;
  // Operations
  typedef enum logic [1:0] {OP_ENTRY = 2'h0, OP_PROG = 2'h1, OP_EXIT = 2'h2, OP_NONE = 2'h3} op_t;
  // Bus commands and unlock addresses
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BYP_ENTRY = 16'h0020;
  localparam logic [15:0] CMD_BYP_PROG = 16'h00a0;
  localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT = 5;
  localparam int ABORT_BIT = 1;
  // Bus timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int T_WE_PULSE_NS = 35;
  localparam int T_ACCESS_NS = 70;
  localparam int T_RECOVER_NS = 25;
  localparam int SYNC_STAGES = 2;
  localparam int WE_CYC = (T_WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC = (T_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
  // State machines
  typedef enum logic [3:0] {E_IDLE = 4'h1, E_SETUP = 4'h2, E_STROBE = 4'h4, E_RECOV = 4'h8} eng_state_t;
  typedef enum logic [4:0] {S_IDLE = 5'h01, S_CMD = 5'h02, S_POLL_A = 5'h04, S_POLL_B = 5'h08,
    S_FINAL = 5'h10} seq_state_t;
endpackage

/* File: flash_cycle_if.sv */
// Purpose: One-cycle request and answer carrier between sequencer and bus engine.
// Assumes: req held until ack; ack is a one-cycle pulse.
// Notes: rdata valid in the ack cycle of a read.
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if #(parameter int ADDR_W = 24);
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport master (output req, output wr, output addr, output wdata, input rdata, input ack);
  modport engine (input req, input wr, input addr, input wdata, output rdata, output ack);
endinterface
`default_nettype wire

/* File: flash_cycle_engine.sv */
// Purpose: Drives one read or write cycle on the flash pins per request.
// Assumes: Read data is asynchronous and passes two flip-flops before use.
// Notes: Both strobes rise and stay high during recovery of every cycle.
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine import flash_host_pkg::*; #(parameter int ADDR_W = 24)
(
  input wire logic aclk,
  input wire logic aresetn,
  flash_cycle_if.engine fc,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  eng_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [15:0] dq_meta, dq_sync, rd, next_rd;
  logic ack, next_ack, next_ce_n, next_oe_n, next_we_n, next_dq_oe;
  logic [ADDR_W-1:0] next_addr;
  logic [15:0] next_dq_out;

  assign fc.ack = ack;
  assign fc.rdata = rd;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_rd = rd;
    next_ack = 1'b0;
    next_ce_n = flash_ce_n;
    next_oe_n = flash_oe_n;
    next_we_n = flash_we_n;
    next_dq_oe = flash_dq_oe;
    next_addr = flash_addr;
    next_dq_out = flash_dq_out;
    case (state)
      E_IDLE:
        // Req still stands in the ack cycle; do not start that cycle again
        if (fc.req && !ack)
        begin
          next_addr = fc.addr;
          next_dq_out = fc.wdata;
          next_dq_oe = fc.wr;
          next_ce_n = 1'b0;
          next_state = E_SETUP;
        end
      E_SETUP:
      begin
        next_we_n = ~fc.wr;
        next_oe_n = fc.wr;
        next_cnt = fc.wr ? 4'(WE_CYC - 1) : 4'(RD_CYC - 1);
        next_state = E_STROBE;
      end
      E_STROBE:
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else
        begin
          next_rd = fc.wr ? rd : dq_sync;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = 4'(REC_CYC - 1);
          next_state = E_RECOV;
        end
      E_RECOV:
        if (cnt != 4'h0)
          next_cnt = cnt - 4'h1;
        else
        begin
          next_dq_oe = 1'b0;
          next_ack = 1'b1;
          next_state = E_IDLE;
        end
      default: next_state = E_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    dq_meta <= flash_dq_in;
    dq_sync <= dq_meta;
    if (!aresetn)
    begin
      state <= E_IDLE;
      cnt <= 4'h0;
      rd <= 16'h0000;
      ack <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      rd <= next_rd;
      ack <= next_ack;
      flash_ce_n <= next_ce_n;
      flash_oe_n <= next_oe_n;
      flash_we_n <= next_we_n;
      flash_dq_oe <= next_dq_oe;
      flash_addr <= next_addr;
      flash_dq_out <= next_dq_out;
    end
  end

  strobe_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flash_oe_n) |-> flash_oe_n [*2])
    else $error("output enable not held high between reads");
  we_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(flash_we_n) |-> flash_dq_oe ##1 (flash_we_n && flash_dq_oe) ##1 (flash_we_n && fc.ack))
    else $error("write strobe not one cycle with data driven through its rise");
endmodule // flash_cycle_engine
`default_nettype wire

/* File: toggle_judge.sv */
// Purpose: Compares two successive status words for the polling decision.
// Assumes: Both words come from distinct read cycles at the same address.
// Notes: Pure decode, no state.
`timescale 1ns/1ps
`default_nettype none
module toggle_judge import flash_host_pkg::*;
(
  input wire logic [15:0] prev,
  input wire logic [15:0] cur,
  output logic toggled,
  output logic limit_hit,
  output logic abort_hit
);
  always_comb
  begin
    toggled = prev[TOGGLE_BIT] ^ cur[TOGGLE_BIT];
    limit_hit = cur[LIMIT_BIT];
    abort_hit = cur[ABORT_BIT];
  end
endmodule // toggle_judge
`default_nettype wire

/* File: flash_bypass_host.sv */
// Purpose: AXI4-Lite controlled host that runs unlock-bypass entry, program and exit on a flash bank.
// Assumes: Software writes BASE, ADDR and DATA before setting go in CTRL.
// Notes: Program completion is found by toggle polling at the program address.
`timescale 1ns/1ps
`default_nettype none
module flash_bypass_host import flash_host_pkg::*; #(parameter int ADDR_W = ADDR_W_DEF)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [REG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [REG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  flash_cycle_if #(.ADDR_W(ADDR_W)) fc ();

  // Bus slave state
  logic take_w, next_take_w, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Sequencer state
  seq_state_t state, next_state;
  op_t op, next_op;
  logic [1:0] step, next_step;
  logic req, next_req, wr, next_wr;
  logic [ADDR_W-1:0] cyc_addr, next_cyc_addr, base, next_base, target, next_target;
  logic [15:0] cyc_data, next_cyc_data, pdata, next_pdata, prev, next_prev, last_rd, next_last_rd;
  logic rechk, next_rechk, done, next_done, fail, next_fail;
  logic bypass, next_bypass, refused, next_refused;
  logic toggled, limit_hit;
  logic [31:0] status;

  assign fc.req = req;
  assign fc.wr = wr;
  assign fc.addr = cyc_addr;
  assign fc.wdata = cyc_data;
  assign awready = take_w;
  assign wready = take_w;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [REG_AW-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_DATA) || (a == OFS_STAT) || (a == OFS_BASE);
  endfunction

  // Address of each command step, offset from the bank base
  function automatic logic [11:0] step_ofs(input op_t o, input logic [1:0] s);
    if (o == OP_ENTRY)
      return (s == 2'h1) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
    return 12'h000;
  endfunction

  function automatic logic [15:0] step_data(input op_t o, input logic [1:0] s);
    case (o)
      OP_ENTRY: return (s == 2'h0) ? CMD_UNLOCK1 : (s == 2'h1) ? CMD_UNLOCK2 : CMD_BYP_ENTRY;
      OP_PROG: return CMD_BYP_PROG;
      default: return (s == 2'h0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
    endcase
  endfunction

  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_BUSY] = (state != S_IDLE);
    status[ST_DONE] = done;
    status[ST_FAIL] = fail;
    status[ST_BYPASS] = bypass;
    status[ST_REFUSED] = refused;
    status[ST_RD_LSB +: 16] = last_rd;
  end

  toggle_judge judge (
    .prev(prev),
    .cur(fc.rdata),
    .toggled(toggled),
    .limit_hit(limit_hit),
    .abort_hit()
  );

  flash_cycle_engine #(.ADDR_W(ADDR_W)) engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .fc(fc),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  // Bus slave: write taken with both channels, read answered the cycle after arready
  always_comb
  begin
    next_take_w = !take_w && awvalid && wvalid && !bvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_arready = !arready && arvalid && !rvalid;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (take_w)
    begin
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFS_ADDR: next_rdata = 32'(target);
        OFS_DATA: next_rdata = {16'h0000, pdata};
        OFS_STAT: next_rdata = status;
        OFS_BASE: next_rdata = 32'(base);
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      take_w <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      take_w <= next_take_w;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Sequencer: command steps, then toggle polling for a program
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_req = req;
    next_wr = wr;
    next_cyc_addr = cyc_addr;
    next_cyc_data = cyc_data;
    next_base = base;
    next_target = target;
    next_pdata = pdata;
    next_prev = prev;
    next_last_rd = last_rd;
    next_rechk = rechk;
    next_done = done;
    next_fail = fail;
    next_bypass = bypass;
    next_refused = refused;
    if (take_w)
      case (awaddr)
        OFS_ADDR: next_target = ADDR_W'(merge(32'(target), wdata, wstrb));
        OFS_DATA: next_pdata = 16'(merge({16'h0000, pdata}, wdata, wstrb));
        OFS_BASE: next_base = ADDR_W'(merge(32'(base), wdata, wstrb));
        OFS_CTRL:
          if (wstrb[0] && wdata[CTRL_GO])
          begin
            // Entry only outside bypass; program and exit only inside it
            if (state != S_IDLE || op_t'(wdata[CTRL_OP_LSB +: 2]) == OP_NONE
                || (op_t'(wdata[CTRL_OP_LSB +: 2]) == OP_ENTRY) == bypass)
              next_refused = 1'b1;
            else
            begin
              next_op = op_t'(wdata[CTRL_OP_LSB +: 2]);
              next_step = 2'h0;
              next_done = 1'b0;
              next_fail = 1'b0;
              next_refused = 1'b0;
              next_rechk = 1'b0;
              next_state = S_CMD;
            end
          end
        default: next_refused = refused;
      endcase
    case (state)
      S_IDLE: next_req = 1'b0;
      S_CMD:
        if (fc.ack)
        begin
          next_req = 1'b0;
          next_step = step + 2'h1;
          if (op == OP_ENTRY && step == 2'h2)
          begin
            next_bypass = 1'b1;
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          else if (op == OP_PROG && step == 2'h1)
            next_state = S_POLL_A;
          else if (op == OP_EXIT && step == 2'h1)
          begin
            next_bypass = 1'b0;
            next_done = 1'b1;
            next_state = S_IDLE;
          end
        end
        else if (!req)
        begin
          next_req = 1'b1;
          next_wr = 1'b1;
          if (op == OP_PROG && step == 2'h1)
          begin
            next_cyc_addr = target;
            next_cyc_data = pdata;
          end
          else
          begin
            next_cyc_addr = ADDR_W'(base + ADDR_W'(step_ofs(op, step)));
            next_cyc_data = step_data(op, step);
          end
        end
      S_POLL_A, S_POLL_B, S_FINAL:
        if (fc.ack)
        begin
          next_req = 1'b0;
          next_prev = fc.rdata;
          next_last_rd = fc.rdata;
          if (state == S_POLL_A)
            next_state = S_POLL_B;
          else if (state == S_FINAL)
          begin
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          else if (!toggled)
            next_state = S_FINAL;
          else if (limit_hit && rechk)
          begin
            next_fail = 1'b1;
            next_op = OP_EXIT;
            next_step = 2'h0;
            next_state = S_CMD;
          end
          else if (limit_hit)
          begin
            next_rechk = 1'b1;
            next_state = S_POLL_A;
          end
        end
        else if (!req)
        begin
          next_req = 1'b1;
          next_wr = 1'b0;
          next_cyc_addr = target;
        end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      op <= OP_NONE;
      step <= 2'h0;
      req <= 1'b0;
      wr <= 1'b0;
      cyc_addr <= '0;
      cyc_data <= 16'h0000;
      base <= '0;
      target <= '0;
      pdata <= 16'h0000;
      prev <= 16'h0000;
      last_rd <= 16'h0000;
      rechk <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      bypass <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      req <= next_req;
      wr <= next_wr;
      cyc_addr <= next_cyc_addr;
      cyc_data <= next_cyc_data;
      base <= next_base;
      target <= next_target;
      pdata <= next_pdata;
      prev <= next_prev;
      last_rd <= next_last_rd;
      rechk <= next_rechk;
      done <= next_done;
      fail <= next_fail;
      bypass <= next_bypass;
      refused <= next_refused;
    end
  end

  entry_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_CMD && op == OP_ENTRY && req && step == 2'h1)
      |-> (cyc_addr == ADDR_W'(base + ADDR_W'(UNLOCK_ADDR2)) && cyc_data == CMD_UNLOCK2 && wr))
    else $error("second unlock word wrong");
  prog_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_CMD && op == OP_PROG && step == 2'h0 && fc.ack)
      |-> ##2 (req && wr && cyc_addr == target && cyc_data == pdata))
    else $error("program data not written at target after setup");
  exit_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_CMD && op == OP_EXIT && step == 2'h1 && fc.ack) |=> (!bypass && state == S_IDLE))
    else $error("bypass not left after exit pair");
  mode_guard_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_CMD && req && (op == OP_PROG || op == OP_EXIT)) |-> bypass)
    else $error("bypass command issued outside bypass mode");
  poll_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req && !wr) |-> (cyc_addr == target && state != S_IDLE && state != S_CMD))
    else $error("status read not at program address");
  confirm_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_POLL_B && fc.ack && !toggled) |=> (state == S_FINAL && !done) ##[1:40] done)
    else $error("completion not confirmed by a following read");
  recheck_fail_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_POLL_B && fc.ack && toggled && limit_hit && rechk)
      |=> (fail && state == S_CMD && op == OP_EXIT && step == 2'h0))
    else $error("failed operation not followed by reset");
  recheck_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_POLL_B && fc.ack && toggled && limit_hit && !rechk) |=> (state == S_POLL_A && rechk && !fail))
    else $error("timing limit without recheck");
endmodule // flash_bypass_host
`default_nettype wire

/* File: flash_bank_model.sv */
// Purpose: Behavioural flash bank facing the bypass host.
// Assumes: Bank base aligned to 4K words; one program in flight.
// Notes: stuck holds the bank busy with the timing-limit flag high; prot skips the array update.
`timescale 1ns/1ps
`default_nettype none
module flash_bank_model import flash_host_pkg::*; #(parameter int ADDR_W = 24)
(
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [15:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic stuck,
  input wire logic prot,
  input wire logic [3:0] busy_len
);
  int step = 0;
  int busy = 0;
  logic byp = 1'b0;
  logic pset = 1'b0;
  logic ex1 = 1'b0;
  logic tog = 1'b0;
  logic [15:0] arr = 16'hffff;
  logic [15:0] pdat = 16'h0000;
  logic [15:0] last = 16'h0000;
  wire logic [11:0] ofs = flash_addr[11:0];
  wire logic [15:0] d = flash_dq_oe ? flash_dq_out : ~last;
  // Commands are taken as the write strobe rises
  always @(posedge flash_we_n)
  begin
    if (!byp)
    begin
      if (step == 2 && d == CMD_BYP_ENTRY && ofs == UNLOCK_ADDR1) byp = 1'b1;
      step = (d == CMD_UNLOCK1 && ofs == UNLOCK_ADDR1) ? 1 :
        (step == 1 && d == CMD_UNLOCK2 && ofs == UNLOCK_ADDR2) ? 2 : 0;
    end
    else if (pset)
    begin
      pset = 1'b0;
      pdat = d;
      busy = busy_len + 1;
    end
    else if (ex1)
    begin
      ex1 = 1'b0;
      if (d == CMD_BYP_EXIT2) byp = 1'b0;
      if (d == CMD_BYP_EXIT2) busy = 0;
    end
    else
    begin
      pset = (d == CMD_BYP_PROG) && busy == 0;
      ex1 = (d == CMD_BYP_EXIT1);
    end
  end
  // Each distinct read advances the status
  always @(negedge flash_oe_n)
  begin
    if (!flash_ce_n && busy != 0)
    begin
      tog = ~tog;
      if (!stuck) busy = busy - 1;
      if (busy == 0 && !prot) arr = pdat;
    end
    // Sector-erase toggle and abort bits stay low during a word program
    last = (busy != 0) ? {8'h00, ~pdat[7], tog, stuck, 5'h00} : arr;
  end
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : (!flash_ce_n && !flash_oe_n) ? last : ~last;
endmodule // flash_bank_model
`default_nettype wire

/* File: flash_bypass_host_tb.sv */
// Purpose: Self-checking bench of the flash unlock-bypass host.
// Assumes: Registers reached over AXI4-Lite; bank model answers every read.
// Notes: Reads queue masked expectations; flash writes are checked as the strobe rises.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module flash_bypass_host_tb import flash_host_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stuck = 0, prot = 0;
  logic [31:0] wdata = 32'h0, seed = 32'h237c0995, g, r32;
  logic [3:0] busy_len = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic [1:0] bresp, rresp, bt;
  logic [31:0] rdata;
  logic [23:0] flash_addr, base, tgt;
  logic [15:0] flash_dq_out, flash_dq_in, dat, prev = 16'hffff;
  logic [67:0] rt;
  logic [40:0] wt;
  int err_total = 0, checked = 0;
  logic [1:0] bq[$];
  logic [67:0] rq[$];
  logic [40:0] wq[$];
  always #25 aclk = ~aclk;
  flash_bypass_host #(.ADDR_W(24)) flash_bypass_host_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n);
  flash_bank_model #(.ADDR_W(24)) flash_bank_model_i (.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .stuck, .prot, .busy_len);
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) err_total++;
    if (n >= 100) end_sim();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] m, input logic [33:0] e);
    int n = 0;
    @(posedge aclk);
    rq.push_back({m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      g = rdata;
      n++;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100) err_total++;
    if (n >= 100) end_sim();
  endtask
  task automatic go(input op_t op);
    wr(OFS_CTRL, {29'h0, op, 1'b1}, 2'h0);
  endtask
  task automatic ew(input logic [11:0] a, input logic [15:0] d);
    wq.push_back({1'b1, base[23:12], a, d});
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 400; n++)
    begin
      rd(OFS_STAT, 34'h0, 34'h0);
      if (g[ST_DONE] === 1'b1 && g[ST_BUSY] === 1'b0) break;
    end
    if (n >= 400) err_total++;
    if (n >= 400) end_sim();
  endtask
  task automatic entry();
    ew(UNLOCK_ADDR1, CMD_UNLOCK1);
    ew(UNLOCK_ADDR2, CMD_UNLOCK2);
    ew(UNLOCK_ADDR1, CMD_BYP_ENTRY);
    go(OP_ENTRY);
    wait_done();
  endtask
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
    begin
      bt = bq.pop_front();
      `CHK("bresp", bt, bresp)
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
    begin
      rt = rq.pop_front();
      if (rt[67:34] != 34'h0) `CHK("read", rt[33:0] & rt[67:34], {rresp, rdata} & rt[67:34])
    end
  end
  always @(posedge flash_we_n)
  begin
    wt = (wq.size() > 0) ? wq.pop_front() : 41'h0;
    if (aresetn === 1'b1) `CHK("flash write", wt, {flash_dq_oe, flash_addr, flash_dq_out})
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STAT, {2'h3, 32'hffffffff}, 34'h0);
    rd(8'h14, {2'h3, 32'hffffffff}, {2'h2, 32'h0});
    wr(8'h14, 32'h1, 2'h2);
    r32 = xorshift();
    base = {r32[23:12], 12'h000};
    wr(OFS_BASE, {8'h0, base}, 2'h0);
    go(OP_PROG);
    rd(OFS_STAT, 34'h1f, 34'h10);
    entry();
    rd(OFS_STAT, 34'h1f, 34'h0a);
    go(OP_ENTRY);
    rd(OFS_STAT, 34'h1f, 34'h1a);
    for (int i = 0; i < 5; i++)
    begin
      r32 = xorshift();
      tgt = {base[23:12], r32[27:16]};
      dat = r32[15:0];
      busy_len <= r32[31:28];
      prot <= (i == 4);
      ew(12'h000, CMD_BYP_PROG);
      wq.push_back({1'b1, tgt, dat});
      wr(OFS_ADDR, {8'h0, tgt}, 2'h0);
      wr(OFS_DATA, {16'h0, dat}, 2'h0);
      go(OP_PROG);
      wait_done();
      if (i < 4) prev = dat;
      rd(OFS_STAT, {2'h3, 32'hffffffff}, {2'h0, prev, 16'h000a});
    end
    stuck <= 1'b1;
    prot <= 1'b0;
    ew(12'h000, CMD_BYP_PROG);
    wq.push_back({1'b1, tgt, dat});
    ew(12'h000, CMD_BYP_EXIT1);
    ew(12'h000, CMD_BYP_EXIT2);
    go(OP_PROG);
    go(OP_EXIT);
    wait_done();
    rd(OFS_STAT, 34'h1f, 34'h16);
    stuck <= 1'b0;
    entry();
    ew(12'h000, CMD_BYP_EXIT1);
    ew(12'h000, CMD_BYP_EXIT2);
    go(OP_EXIT);
    wait_done();
    rd(OFS_STAT, 34'h1f, 34'h02);
    go(OP_NONE);
    rd(OFS_STAT, 34'h1f, 34'h12);
    repeat (4) @(posedge aclk);
    `CHK("writes left", 0, wq.size())
    end_sim();
  end
endmodule // flash_bypass_host_tb
`default_nettype wire
